// *** pjs_consts.svh ***
// constants for the program jog profile sequencer: offsets, fields, defaults, timing
// assumes a 40 MHz core clock and a 32-bit APB register bus
`ifndef PJS_CONSTS_SVH
`define PJS_CONSTS_SVH
`define PJS_OFF_P0_TURNS 12'h000
`define PJS_OFF_P0_SPEED 12'h004
`define PJS_OFF_P0_RAMP 12'h008
`define PJS_OFF_P0_DWELL 12'h00c
`define PJS_OFF_P1_TURNS 12'h010
`define PJS_OFF_P1_SPEED 12'h014
`define PJS_OFF_P1_RAMP 12'h018
`define PJS_OFF_P1_DWELL 12'h01c
`define PJS_OFF_CTRL 12'h020
`define PJS_OFF_STATUS 12'h024
`define PJS_OFF_POS 12'h028
`define PJS_OFF_SPEED 12'h02c
`define PJS_CTRL_RUN 0
`define PJS_CTRL_STOP 1
`define PJS_CTRL_SERVO_ON 2
`define PJS_CTRL_SERVO_OFF 3
`define PJS_CTRL_SESSION 4
`define PJS_CTRL_PANEL_FN 5
`define PJS_TURNS_MIN (-50)
`define PJS_TURNS_MAX 50
`define PJS_P0_TURNS_RST 8'sh05
`define PJS_P1_TURNS_RST 8'shfb
`define PJS_SPEED_MIN 12'h064
`define PJS_SPEED_MAX 12'hbb8
`define PJS_SPEED_RST 12'h3e8
`define PJS_RAMP_MIN 11'h032
`define PJS_RAMP_MAX 11'h7d0
`define PJS_RAMP_RST 11'h1f4
`define PJS_DWELL_MIN 14'h0064
`define PJS_DWELL_MAX 14'h2710
`define PJS_DWELL_RST 14'h03e8
`define PJS_CLK_HZ 40000000
`define PJS_MS_PER_S 1000
`define PJS_MS_CYCLES (`PJS_CLK_HZ / `PJS_MS_PER_S)
`define PJS_POS_PER_REV 60000
`define PJS_PANEL_FN_NUM 8'h12
`endif

// *** pjs_pkg.sv ***
// types for the program jog profile sequencer
// assumes pjs_consts.svh supplies the numbers
package pjs_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ACCEL = 3'b001,
    ST_CRUISE = 3'b010,
    ST_DECEL = 3'b011,
    ST_DWELL = 3'b100
  } pjs_state_type;
  typedef struct packed {
    logic signed [7:0] turns;
    logic [11:0] speed;
    logic [10:0] ramp;
    logic [13:0] dwell;
  } pjs_pattern_type;
  typedef struct packed {
    logic params_writable;
    logic main_power;
    logic alarm;
    logic safe_state;
    logic fwd_limit;
    logic rev_limit;
  } pjs_cond_type;
  typedef struct packed {
    logic mode_key;
    logic left_key;
  } pjs_keys_type;
endpackage

// *** pjs_sequencer.sv ***
// program jog profile sequencer: APB register file, start checks and speed profile
// assumes asynchronous status pins and panel keys from outside; they get two flops here
`timescale 1ns/100ps
`include "pjs_consts.svh"
module pjs_sequencer (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire pjs_pkg::pjs_cond_type COND,
  input wire pjs_pkg::pjs_keys_type KEYS,
  output logic SERVO_ON,
  output logic RUNNING,
  output logic signed [15:0] SPEED_CMD,
  output logic signed [31:0] POS_CMD
);
  import pjs_pkg::*;

  // clamp helpers shared by the writes of both patterns
  function automatic logic [11:0] clamp_speed(input logic [31:0] v);
    if (v < 32'(`PJS_SPEED_MIN)) return `PJS_SPEED_MIN;
    if (v > 32'(`PJS_SPEED_MAX)) return `PJS_SPEED_MAX;
    return v[11:0];
  endfunction
  function automatic logic [10:0] clamp_ramp(input logic [31:0] v);
    if (v < 32'(`PJS_RAMP_MIN)) return `PJS_RAMP_MIN;
    if (v > 32'(`PJS_RAMP_MAX)) return `PJS_RAMP_MAX;
    return v[10:0];
  endfunction
  function automatic logic [13:0] clamp_dwell(input logic [31:0] v);
    if (v < 32'(`PJS_DWELL_MIN)) return `PJS_DWELL_MIN;
    if (v > 32'(`PJS_DWELL_MAX)) return `PJS_DWELL_MAX;
    return v[13:0];
  endfunction
  function automatic logic signed [7:0] clamp_turns(input logic [31:0] v);
    if ($signed(v) < `PJS_TURNS_MIN) return 8'(`PJS_TURNS_MIN);
    if ($signed(v) > `PJS_TURNS_MAX) return 8'(`PJS_TURNS_MAX);
    return v[7:0];
  endfunction
  function automatic pjs_pattern_type write_pat(input pjs_pattern_type p,
      input logic [1:0] fld, input logic [31:0] v);
    pjs_pattern_type r;
    r = p;
    case (fld)
      2'h0: r.turns = clamp_turns(v);
      2'h1: r.speed = clamp_speed(v);
      2'h2: r.ramp = clamp_ramp(v);
      default: r.dwell = clamp_dwell(v);
    endcase
    return r;
  endfunction

  // two-flop synchronisers for the pins
  pjs_cond_type cond_m_ff, cond_s_ff;
  pjs_keys_type keys_m_ff, keys_s_ff, keys_d_ff;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      cond_m_ff <= '0;
      cond_s_ff <= '0;
      keys_m_ff <= '0;
      keys_s_ff <= '0;
      keys_d_ff <= '0;
    end else begin
      cond_m_ff <= COND;
      cond_s_ff <= cond_m_ff;
      keys_m_ff <= KEYS;
      keys_s_ff <= keys_m_ff;
      keys_d_ff <= keys_s_ff;
    end
  end
  logic mode_press, left_press, precond_ok;
  assign mode_press = keys_s_ff.mode_key & ~keys_d_ff.mode_key;
  assign left_press = keys_s_ff.left_key & ~keys_d_ff.left_key;

  // register state and sequencer state
  pjs_pattern_type pat_ff [2];
  pjs_pattern_type nxt_pat [2];
  logic session_ff, nxt_session, panel_fn_ff, nxt_panel_fn, servo_ff, nxt_servo;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  pjs_state_type state_ff, nxt_state;
  logic pat_sel_ff, nxt_pat_sel;
  logic [15:0] tick_ff, nxt_tick;
  logic [13:0] ms_ff, nxt_ms;
  logic [31:0] speed_ff, nxt_speed;
  logic [31:0] trav_ff, nxt_trav;
  logic [31:0] brake_ff, nxt_brake;
  logic signed [31:0] pos_ff, nxt_pos;
  logic [2:0] start_err_ff, nxt_start_err;
  logic running_ff, nxt_running;
  logic signed [15:0] speed_cmd_ff, nxt_speed_cmd;

  // preconditions: only checked at start, servo must still be off
  assign precond_ok = cond_s_ff.params_writable & cond_s_ff.main_power & ~cond_s_ff.alarm
                      & ~cond_s_ff.safe_state & ~cond_s_ff.fwd_limit & ~cond_s_ff.rev_limit;

  logic wr_acc, rd_acc, ctrl_wr;
  assign wr_acc = PSEL & PENABLE & PWRITE;
  assign rd_acc = PSEL & ~PENABLE & ~PWRITE;
  assign ctrl_wr = wr_acc & (PADDR == `PJS_OFF_CTRL);

  pjs_pattern_type cur;
  logic [31:0] dist_total, ramp_cycles, step;
  always_comb begin
    cur = pat_ff[pat_sel_ff];
    // position units: 1/60000 of a turn, one rpm held for one ms
    dist_total = 32'(`PJS_POS_PER_REV) * 32'($unsigned(cur.turns[7] ? -cur.turns : cur.turns));
    ramp_cycles = 32'(cur.ramp);
    step = (32'(cur.speed) + ramp_cycles - 32'h1) / ramp_cycles;
  end

  // APB slave: one wait-free access, unmapped addresses answer with an error
  always_comb begin
    nxt_pat[0] = pat_ff[0];
    nxt_pat[1] = pat_ff[1];
    nxt_session = session_ff;
    nxt_panel_fn = panel_fn_ff;
    nxt_prdata = prdata_ff;
    nxt_pready = PSEL & ~PENABLE;
    nxt_pslverr = 1'b0;
    if (wr_acc && PADDR < `PJS_OFF_CTRL && PADDR[1:0] == 2'h0) begin
      nxt_pat[PADDR[4]] = write_pat(pat_ff[PADDR[4]], PADDR[3:2], PWDATA);
    end
    if (ctrl_wr) begin
      nxt_session = PWDATA[`PJS_CTRL_SESSION];
      nxt_panel_fn = PWDATA[`PJS_CTRL_PANEL_FN];
    end
    if (left_press) begin
      nxt_panel_fn = 1'b0;
    end
    // read data is caught at the setup edge so it stands together with PREADY
    if (rd_acc) begin
      case (PADDR)
        `PJS_OFF_P0_TURNS, `PJS_OFF_P1_TURNS: nxt_prdata = 32'(signed'(pat_ff[PADDR[4]].turns));
        `PJS_OFF_P0_SPEED, `PJS_OFF_P1_SPEED: nxt_prdata = 32'(pat_ff[PADDR[4]].speed);
        `PJS_OFF_P0_RAMP, `PJS_OFF_P1_RAMP: nxt_prdata = 32'(pat_ff[PADDR[4]].ramp);
        `PJS_OFF_P0_DWELL, `PJS_OFF_P1_DWELL: nxt_prdata = 32'(pat_ff[PADDR[4]].dwell);
        `PJS_OFF_CTRL: nxt_prdata = {26'h0, panel_fn_ff, session_ff, 4'h0};
        `PJS_OFF_STATUS: nxt_prdata = {24'h0, start_err_ff, pat_sel_ff, servo_ff, state_ff};
        `PJS_OFF_POS: nxt_prdata = pos_ff;
        `PJS_OFF_SPEED: nxt_prdata = speed_ff;
        default: nxt_prdata = 32'h0;
      endcase
    end
    if (PSEL && !PENABLE && (PADDR > `PJS_OFF_SPEED || PADDR[1:0] != 2'h0)) begin
      nxt_pslverr = 1'b1;
    end
  end

  // sequencer: accel, cruise, decel, dwell per pattern, alternating
  logic stop_req, start_req, ms_tick;
  // the ms divider runs free from reset: the first profile step after a start
  // lands anywhere inside one ms, traded for a smaller start path
  assign ms_tick = (tick_ff == 16'(`PJS_MS_CYCLES - 1));
  always_comb begin
    stop_req = (ctrl_wr & PWDATA[`PJS_CTRL_STOP])
               | (session_ff & ~nxt_session)
               | (ctrl_wr & PWDATA[`PJS_CTRL_SERVO_OFF])
               | left_press;
    // run from the PC needs servo on first; panel mode key does both
    start_req = (ctrl_wr & PWDATA[`PJS_CTRL_RUN] & servo_ff)
                | (mode_press & panel_fn_ff & precond_ok & ~servo_ff);
    nxt_state = state_ff;
    nxt_pat_sel = pat_sel_ff;
    nxt_servo = servo_ff;
    nxt_tick = ms_tick ? 16'h0 : tick_ff + 16'h1;
    nxt_ms = ms_ff;
    nxt_speed = speed_ff;
    nxt_trav = trav_ff;
    nxt_brake = brake_ff;
    nxt_pos = pos_ff;
    nxt_start_err = start_err_ff;
    if (ctrl_wr && PWDATA[`PJS_CTRL_SERVO_ON] && !servo_ff) begin
      if (precond_ok) begin
        nxt_servo = 1'b1;
      end else begin
        nxt_start_err = start_err_ff + 3'h1;
      end
    end
    case (state_ff)
      ST_IDLE: begin
        nxt_speed = 32'h0;
        if (start_req) begin
          nxt_servo = 1'b1;
          nxt_pat_sel = 1'b0;
          nxt_trav = 32'h0;
          nxt_state = ST_ACCEL;
        end
      end
      ST_ACCEL, ST_CRUISE, ST_DECEL: begin
        // one profile step per ms: speed rpm, travel accumulates rpm-ms
        if (ms_tick) begin
          // distance to stop from here, triangle rule: v*v/(2*step)
          nxt_brake = (speed_ff * speed_ff) / (32'h2 * step);
          if (state_ff != ST_DECEL && trav_ff + speed_ff + nxt_brake + speed_ff >= dist_total) begin
            nxt_state = ST_DECEL;
          end else if (state_ff == ST_ACCEL) begin
            nxt_speed = (speed_ff + step >= 32'(cur.speed)) ? 32'(cur.speed) : speed_ff + step;
            if (speed_ff + step >= 32'(cur.speed)) begin
              nxt_state = ST_CRUISE;
            end
          end else if (state_ff == ST_CRUISE) begin
            nxt_speed = 32'(cur.speed);
          end
          if (nxt_state == ST_DECEL) begin
            nxt_speed = (speed_ff > step) ? speed_ff - step : 32'h1;
          end
          // clip the final step so the travel lands exactly
          if (trav_ff + nxt_speed >= dist_total) begin
            nxt_speed = (trav_ff >= dist_total) ? 32'h0 : dist_total - trav_ff;
            nxt_state = ST_DWELL;
            nxt_ms = 14'h0;
          end
          nxt_trav = trav_ff + nxt_speed;
          nxt_pos = cur.turns[7] ? pos_ff - $signed(nxt_speed) : pos_ff + $signed(nxt_speed);
          if (dist_total == 32'h0) begin
            nxt_state = ST_DWELL;
            nxt_ms = 14'h0;
            nxt_speed = 32'h0;
          end
        end
      end
      ST_DWELL: begin
        nxt_speed = 32'h0;
        if (ms_tick) begin
          nxt_ms = ms_ff + 14'h1;
          if (ms_ff + 14'h1 >= cur.dwell) begin
            nxt_pat_sel = ~pat_sel_ff;
            nxt_trav = 32'h0;
            nxt_state = ST_ACCEL;
          end
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (stop_req) begin
      nxt_state = ST_IDLE;
      nxt_speed = 32'h0;
      nxt_servo = ~(ctrl_wr & PWDATA[`PJS_CTRL_SERVO_OFF]) & ~left_press & servo_ff;
    end
    // outputs leave from flops; built from next values so they line up with the state
    nxt_running = (nxt_state != ST_IDLE);
    nxt_speed_cmd = nxt_pat[nxt_pat_sel].turns[7] ? -$signed(nxt_speed[15:0])
                    : $signed(nxt_speed[15:0]);
  end

  // register every group
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      pat_ff[0] <= '{`PJS_P0_TURNS_RST, `PJS_SPEED_RST, `PJS_RAMP_RST, `PJS_DWELL_RST};
      pat_ff[1] <= '{`PJS_P1_TURNS_RST, `PJS_SPEED_RST, `PJS_RAMP_RST, `PJS_DWELL_RST};
      session_ff <= 1'b0;
      panel_fn_ff <= 1'b0;
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      state_ff <= ST_IDLE;
      pat_sel_ff <= 1'b0;
      servo_ff <= 1'b0;
      tick_ff <= 16'h0;
      ms_ff <= 14'h0;
      speed_ff <= 32'h0;
      trav_ff <= 32'h0;
      brake_ff <= 32'h0;
      pos_ff <= 32'sh0;
      start_err_ff <= 3'h0;
      running_ff <= 1'b0;
      speed_cmd_ff <= 16'sh0;
    end else begin
      pat_ff[0] <= nxt_pat[0];
      pat_ff[1] <= nxt_pat[1];
      session_ff <= nxt_session;
      panel_fn_ff <= nxt_panel_fn;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      state_ff <= nxt_state;
      pat_sel_ff <= nxt_pat_sel;
      servo_ff <= nxt_servo;
      tick_ff <= nxt_tick;
      ms_ff <= nxt_ms;
      speed_ff <= nxt_speed;
      trav_ff <= nxt_trav;
      brake_ff <= nxt_brake;
      pos_ff <= nxt_pos;
      start_err_ff <= nxt_start_err;
      running_ff <= nxt_running;
      speed_cmd_ff <= nxt_speed_cmd;
    end
  end

  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign SERVO_ON = servo_ff;
  assign RUNNING = running_ff;
  assign SPEED_CMD = speed_cmd_ff;
  assign POS_CMD = pos_ff;
endmodule

// *** pjs_sequencer_asserts.sv ***
// checker for the jog sequencer ports: bus answers, setting ranges, stop paths
// assumes the sequencer's own port names; it is bound at the foot of this file
`timescale 1ns/100ps
module pjs_sequencer_chk (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic SERVO_ON,
  input wire logic RUNNING,
  input wire logic signed [15:0] SPEED_CMD
);
  import pjs_pkg::*;
  logic sess_ff;
  logic nxt_sess;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_ctrl_wr;
    PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h020;
  endsequence
  // session level mirrored, so a close is told apart from a repeated zero
  always_comb begin
    nxt_sess = sess_ff;
    if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h020) nxt_sess = PWDATA[4];
  end
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) sess_ff <= 1'b0;
    else sess_ff <= nxt_sess;
  end
  // a read of either pattern's copy must come back inside its range
  property p_rd(logic [11:0] a, logic [31:0] lo, logic [31:0] hi);
    s_setup ##0 (!PWRITE && (PADDR == a || PADDR == a + 12'h010))
      |=> PREADY && PRDATA >= lo && PRDATA <= hi;
  endproperty
  AST_TURNS: assert property (
    s_setup ##0 (!PWRITE && (PADDR == 12'h000 || PADDR == 12'h010)) |=> PREADY
      && $signed(PRDATA[7:0]) >= -8'sd50 && $signed(PRDATA[7:0]) <= 8'sd50)
    else $error("turns read outside range");
  AST_PEAK: assert property (p_rd(12'h004, 32'h64, 32'hbb8))
    else $error("peak speed read outside range");
  AST_RAMP: assert property (p_rd(12'h008, 32'h32, 32'h7d0))
    else $error("ramp time read outside range");
  AST_DWELL: assert property (p_rd(12'h00c, 32'h64, 32'h2710))
    else $error("dwell time read outside range");
  AST_SPEED_LIM: assert property (SPEED_CMD <= 16'sd3000 && SPEED_CMD >= -16'sd3000)
    else $error("speed command beyond peak limit");
  AST_RUN_SERVO: assert property (RUNNING |-> SERVO_ON)
    else $error("running with servo off");
  AST_STOP: assert property (s_ctrl_wr ##0 PWDATA[1] |=> !RUNNING && SPEED_CMD == 16'sd0)
    else $error("stop command did not halt");
  AST_CLOSE: assert property (s_ctrl_wr ##0 (sess_ff && !PWDATA[4]) |=> !RUNNING)
    else $error("session close did not halt");
endmodule
bind pjs_sequencer pjs_sequencer_chk u_chk (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .SERVO_ON(SERVO_ON), .RUNNING(RUNNING),
  .SPEED_CMD(SPEED_CMD));

// *** pjs_panel_model.sv ***
// operator panel and drive status pins as the sequencer sees them
// assumes the bench calls its tasks; every change follows a rising edge
`timescale 1ns/100ps
module pjs_panel_model (
  input wire logic clk,
  output pjs_pkg::pjs_cond_type cond,
  output pjs_pkg::pjs_keys_type keys
);
  import pjs_pkg::*;
  // healthy drive at start: writable, powered, no alarm, no limit
  initial begin
    cond = 6'b110000;
    keys = 2'b00;
  end
  // raising an alarm breaks the start conditions on purpose
  task set_alarm(input logic a);
    @(posedge clk);
    cond.alarm <= a;
  endtask
  // a key is held long enough to pass the two sync flops
  task press(input logic left);
    @(posedge clk);
    if (left) keys.left_key <= 1'b1;
    else keys.mode_key <= 1'b1;
    repeat (4) @(posedge clk);
    keys <= 2'b00;
    repeat (4) @(posedge clk);
  endtask
endmodule

// *** testbench.sv ***
// bench for the jog sequencer: settings, start checks, stop paths, panel keys
// assumes a 40 MHz clock; only the first one or two profile steps are watched to keep runs short
`timescale 1ns/100ps
`include "pjs_consts.svh"
module testbench;
  import pjs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic servo_on;
  logic running;
  logic signed [15:0] speed_cmd;
  logic signed [31:0] pos_cmd;
  pjs_cond_type cond;
  pjs_keys_type keys;
  logic [31:0] rdat;
  logic rerr;
  int err_total = 0;
  int compares = 0;
  always #12.5 clk = ~clk;
  pjs_sequencer dut (.CORE_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .COND(cond), .KEYS(keys), .SERVO_ON(servo_on), .RUNNING(running),
    .SPEED_CMD(speed_cmd), .POS_CMD(pos_cmd));
  pjs_panel_model panel (.clk(clk), .cond(cond), .keys(keys));
  task test_done;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one bus cycle; a slave that never answers ends the run
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_total++;
      test_done;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // let the answering edge's updates land before looking
  task settle;
    repeat (2) @(negedge clk);
  endtask
  task t_defaults;
    logic [31:0] e [8] = '{32'h5, 32'h3e8, 32'h1f4, 32'h3e8, 32'hfb, 32'h3e8, 32'h1f4, 32'h3e8};
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(i % 4 == 0 ? {24'h0, rdat[7:0]} : rdat, e[i]);
    end
    $display("defaults done");
  endtask
  // out-of-range writes clamp and read back at once
  task t_clamp;
    logic [11:0] a [5] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h014};
    logic [31:0] w [5] = '{32'd60, 32'd5000, 32'd10, 32'd20000, 32'd10};
    logic [31:0] e [5] = '{32'h32, 32'hbb8, 32'h32, 32'h2710, 32'h64};
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, a[i], w[i]);
      apb(1'b0, a[i], 32'h0);
      chk(i == 0 ? {24'h0, rdat[7:0]} : rdat, e[i]);
    end
    apb(1'b1, 12'h010, -32'sd60);
    apb(1'b0, 12'h010, 32'h0);
    chk({24'h0, rdat[7:0]}, 32'hce);
    apb(1'b0, 12'h030, 32'h0);
    chk({rdat[30:0], rerr}, 32'h1);
    $display("clamp done");
  endtask
  // refused start under alarm, then a proper start and a stop
  task t_start;
    panel.set_alarm(1'b1);
    repeat (4) @(posedge clk);
    apb(1'b1, `PJS_OFF_CTRL, 32'h14);
    apb(1'b1, `PJS_OFF_CTRL, 32'h11);
    settle;
    chk({servo_on, running}, 32'h0);
    apb(1'b0, `PJS_OFF_STATUS, 32'h0);
    chk(rdat[7:5], 32'h1);
    panel.set_alarm(1'b0);
    repeat (4) @(posedge clk);
    apb(1'b1, `PJS_OFF_CTRL, 32'h14);
    apb(1'b1, `PJS_OFF_CTRL, 32'h11);
    settle;
    chk({servo_on, running}, 32'h3);
    apb(1'b0, `PJS_OFF_STATUS, 32'h0);
    chk(rdat[4:0], 32'h9);
    repeat (40010) @(posedge clk);
    chk(speed_cmd == 16'sd60 || speed_cmd == 16'sd120, 32'h1);
    apb(1'b1, `PJS_OFF_CTRL, 32'h12);
    settle;
    chk({servo_on, running, speed_cmd}, 32'h20000);
    chk(pos_cmd == 32'sd60 || pos_cmd == 32'sd180, 32'h1);
    $display("start done");
  endtask
  task t_close;
    apb(1'b1, `PJS_OFF_CTRL, 32'h11);
    settle;
    chk(running, 32'h1);
    apb(1'b1, `PJS_OFF_CTRL, 32'h00);
    settle;
    chk(running, 32'h0);
    $display("close done");
  endtask
  task t_panel;
    apb(1'b1, `PJS_OFF_CTRL, 32'h08);
    apb(1'b1, `PJS_OFF_CTRL, 32'h20);
    settle;
    chk(servo_on, 32'h0);
    panel.press(1'b0);
    settle;
    chk({servo_on, running}, 32'h3);
    panel.press(1'b1);
    settle;
    chk(running, 32'h0);
    $display("panel done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_defaults;
    t_clamp;
    t_start;
    t_close;
    t_panel;
    test_done;
  end
endmodule
